// ### design/cmd_pkg.sv
// Shared constants and types for the cascadable multiply/divide unit
package cmd_pkg;

  // Register select codes, also the index into the operand storage
  localparam logic [1:0] SEL_X = 2'h0;
  localparam logic [1:0] SEL_Z = 2'h1;
  localparam logic [1:0] SEL_Y = 2'h2;
  localparam logic [1:0] SEL_CTRL = 2'h3;
  localparam int NUM_OPERANDS = 3;

  // Control word fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_MSB = 1;
  localparam int CTRL_CLR_Z = 2;
  localparam int CTRL_CLR_Y = 3;
  localparam int CTRL_UNITS_LSB = 4;
  localparam int CTRL_UNITS_MSB = 5;
  localparam int CTRL_SEQ_RST = 6;
  localparam int CTRL_PRESCALE = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Operation codes in control bits 1:0
  localparam logic [1:0] OP_MUL = 2'h1;
  localparam logic [1:0] OP_DIV = 2'h2;

  // Status byte: overflow in bit 0, the rest reads zero
  localparam int STATUS_OVF_BIT = 0;
  localparam logic [6:0] STATUS_PAD = 7'h00;

  // Chain position and sequence counters
  localparam logic [1:0] POS_MOST = 2'h3;
  localparam logic [1:0] SEQ_START = 2'h3;

  // Unit count from control bits 5:4 is four minus the code
  localparam logic [2:0] UNITS_BASE = 3'h4;
  localparam logic [2:0] BITS_PER_UNIT_LOG2 = 3'h3;
  localparam logic [5:0] SHIFTS_EXTRA = 6'h01;

  // Prescaler masks: divide by mask plus one
  localparam logic [2:0] RATE_DIRECT = 3'h0;
  localparam logic [2:0] RATE_ONE_UNIT = 3'h1;
  localparam logic [2:0] RATE_TWO_UNITS = 3'h3;
  localparam logic [2:0] RATE_MORE_UNITS = 3'h7;

  // Operation sequencing state
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MUL = 3'b010,
    ST_DIV = 3'b100
  } cmd_state_type;

endpackage : cmd_pkg

// ### design/cmd_shift_gen.sv
// Shift pulse generator with prescaler for the chain's timing line
`timescale 1ns/1ps
module cmd_shift_gen (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  // Control
  input wire logic clear,
  input wire logic start,
  input wire logic [5:0] shift_total,
  input wire logic [2:0] rate_mask,
  // Pulses
  output logic shift_pulse,
  output logic busy
);
  import cmd_pkg::*;

  logic [5:0] left_reg;
  logic [5:0] left_next;
  logic [2:0] div_reg;
  logic [2:0] div_next;
  logic [2:0] mask_reg;
  logic pulse_reg;
  logic pulse_next;
  logic running;
  logic tick;

  // Counting its own pulses keeps the gen from overrunning the operation
  assign running = (left_reg != 6'h00);
  assign tick = running && (div_reg == mask_reg);
  assign pulse_next = tick;
  assign left_next = start ? shift_total :
                     tick ? left_reg - 6'h01 : left_reg;
  assign div_next = (start || tick) ? 3'h0 :
                    running ? div_reg + 3'h1 : div_reg;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      left_reg <= 6'h00;
      div_reg <= 3'h0;
      mask_reg <= RATE_DIRECT;
      pulse_reg <= 1'b0;
    end else if (clk_en) begin
      if (clear) begin
        left_reg <= 6'h00;
        div_reg <= 3'h0;
        pulse_reg <= 1'b0;
      end else begin
        left_reg <= left_next;
        div_reg <= div_next;
        pulse_reg <= pulse_next;
        if (start) begin
          mask_reg <= rate_mask;
        end
      end
    end
  end

  assign shift_pulse = pulse_reg;
  assign busy = running;

endmodule : cmd_shift_gen

// ### design/cmd_unit.sv
// One cascadable 8-bit multiply/divide unit with its host bus and chain
// Functional notes
// - Unit answers its select lines only while unit_select_high is high.
// - Low clear resets sequence counters, shift generator, control bits 0-1.
// - shift_path_control picks add/subtract or plain shift on each step.
// - Most significant unit shows overflow low on carry pin, driven when selected.
// - Overflow latched on each control write; valid only after a divide.
// - Lesser units pass carry upward; least significant carry_in held high.
// - Right ports drive during multiply, left ports drive otherwise.
// - Chain is wired as a ring through ports and shift_path_control.
// - Most significant unit drives the shift line; others listen to it.
// - An operation takes 8N+1 shift pulses for N cascaded units.
// - Only most significant clock matters; control bit 7 picks prescaling.
// - Writes capture bus data on the falling strobe edge; strobe asynchronous.
// - Each strobe to an operand register steps that register's sequence counter; control has none.
// - reg_select_2 is a second unit enable, not gating the overflow driver.
// - Bus floats and nothing happens when disabled or writing without strobe.
// - Reads return multiplier, lower, upper accumulator or status by code.
// - Writes load multiplier, lower, upper accumulator or control by code.
// - Status bit 0 is overflow; bits 1 to 7 read zero.
// - Shift rate is clock, or clock over 2, 4 or 8 with prescaler.
// - Position code straps mark chain place, both high for most significant.
// - A unit answers an operand access only when its counter matches its position.
// - Control bits 4 and 5 give the unit count and prescale ratio.
// - Divide leaves quotient low, remainder high, divisor unchanged.
// - Multiply leaves multiplier times lower plus prior upper in the pair.
`timescale 1ns/1ps
module cmd_unit (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  // Host bus
  input wire logic [7:0] bus_data_in,
  output logic [7:0] bus_data_out,
  output logic bus_data_oe,
  input wire logic unit_select_high,
  input wire logic reg_select_2,
  input wire logic reg_select_1,
  input wire logic reg_select_0,
  input wire logic read_write_select,
  input wire logic bus_strobe,
  input wire logic clear_n,
  // Chain position straps
  input wire logic position_code_hi,
  input wire logic position_code_lo,
  // Carry chain
  input wire logic carry_in,
  output logic carry_out_overflow_n_out,
  output logic carry_out_overflow_n_oe,
  input wire logic shift_path_control,
  // Serial ports between cascaded units
  input wire logic upper_left_in,
  output logic upper_left_out,
  output logic upper_left_oe,
  input wire logic upper_right_in,
  output logic upper_right_out,
  output logic upper_right_oe,
  input wire logic lower_left_in,
  output logic lower_left_out,
  output logic lower_left_oe,
  input wire logic lower_right_in,
  output logic lower_right_out,
  output logic lower_right_oe,
  // Shared shift line
  input wire logic shift_in,
  output logic shift_out,
  output logic shift_oe
);
  import cmd_pkg::*;

  // Pin synchronisers: select lines, clear, straps and data
  localparam int ASYNC_W = 16;
  logic [ASYNC_W-1:0] async_s1_reg;
  logic [ASYNC_W-1:0] async_s2_reg;
  logic strobe_s1_reg;
  logic strobe_s2_reg;
  logic strobe_s3_reg;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      async_s1_reg <= '0;
      async_s2_reg <= '0;
      strobe_s1_reg <= 1'b0;
      strobe_s2_reg <= 1'b0;
      strobe_s3_reg <= 1'b0;
    end else if (clk_en) begin
      async_s1_reg <= {unit_select_high, reg_select_2, reg_select_1,
                       reg_select_0, read_write_select, clear_n,
                       position_code_hi, position_code_lo, bus_data_in};
      async_s2_reg <= async_s1_reg;
      strobe_s1_reg <= bus_strobe;
      strobe_s2_reg <= strobe_s1_reg;
      strobe_s3_reg <= strobe_s2_reg;
    end
  end

  wire logic sel_high = async_s2_reg[15];
  wire logic sel_2 = async_s2_reg[14];
  wire logic [1:0] sel_code = async_s2_reg[13:12];
  wire logic rw_read = async_s2_reg[11];
  wire logic clear_sync = ~async_s2_reg[10];
  wire logic [1:0] pos_code = async_s2_reg[9:8];
  wire logic [7:0] wr_data = async_s2_reg[7:0];

  // Data is synchronised alongside the strobe, so it lines up at the edge
  wire logic strobe_fall = strobe_s3_reg & ~strobe_s2_reg;
  wire logic unit_en = sel_high & sel_2;
  wire logic is_most = (pos_code == POS_MOST);
  wire logic access_edge = strobe_fall & unit_en;
  wire logic wr_edge = access_edge & ~rw_read;

  // State
  cmd_state_type state_reg;
  cmd_state_type state_next;
  logic [7:0] operand_reg [0:NUM_OPERANDS-1];
  logic [7:0] ctrl_reg;
  logic overflow_reg;
  logic [5:0] step_reg;
  logic [5:0] total_reg;
  logic [1:0] seq_cnt_reg [0:NUM_OPERANDS-1];
  logic [NUM_OPERANDS-1:0] seq_match;
  logic [NUM_OPERANDS-1:0] wr_hit;

  wire logic [7:0] x_val = operand_reg[SEL_X];
  wire logic [7:0] y_val = operand_reg[SEL_Y];
  wire logic [7:0] z_val = operand_reg[SEL_Z];

  // Control write decode; it reaches every unit at once
  wire logic ctrl_wr = wr_edge & (sel_code == SEL_CTRL);
  wire logic [1:0] wr_op = wr_data[CTRL_OP_MSB:CTRL_OP_LSB];
  wire logic [1:0] wr_units = wr_data[CTRL_UNITS_MSB:CTRL_UNITS_LSB];
  wire logic op_start = ctrl_wr & (state_reg == ST_IDLE) &
                        ((wr_op == OP_MUL) || (wr_op == OP_DIV));
  wire logic seq_reset = clear_sync |
                         (ctrl_wr & wr_data[CTRL_SEQ_RST]);

  // Unit count and shift total, 8N+1
  wire logic [2:0] n_units = UNITS_BASE - {1'b0, wr_units};
  wire logic [5:0] shift_total =
    ({3'h0, n_units} << BITS_PER_UNIT_LOG2) + SHIFTS_EXTRA;
  wire logic [2:0] rate_mask =
    ~wr_data[CTRL_PRESCALE] ? RATE_DIRECT :
    (n_units == 3'h1) ? RATE_ONE_UNIT :
    (n_units == 3'h2) ? RATE_TWO_UNITS : RATE_MORE_UNITS;

  // Shift pulses: generated here on the head unit, taken from the line
  logic gen_pulse;
  cmd_shift_gen u_shift_gen (
    .clock(clock),
    .reset(reset),
    .clk_en(clk_en),
    .clear(clear_sync),
    .start(op_start),
    .shift_total(shift_total),
    .rate_mask(rate_mask),
    .shift_pulse(gen_pulse),
    .busy()
  );
  // Lesser units ignore their clock for timing, following the line
  wire logic step_pulse = is_most ? gen_pulse : shift_in;

  wire logic in_mul = (state_reg == ST_MUL);
  wire logic in_div = (state_reg == ST_DIV);
  wire logic busy_step = step_pulse & (in_mul | in_div);
  wire logic first_step = (step_reg == 6'h00);
  wire logic last_step = (step_reg == total_reg - SHIFTS_EXTRA);
  wire logic do_step = busy_step & ~first_step;
  wire logic div_shifting = in_div & ~first_step;

  // Multiply: add multiplier when the chain's low bit is set, shift right
  wire logic [8:0] mul_sum = {1'b0, y_val} +
    {1'b0, shift_path_control ? x_val : 8'h00} +
    {8'h00, ~carry_in};
  wire logic [7:0] mul_y = {is_most ? mul_sum[8] : upper_left_in,
                            mul_sum[7:1]};
  wire logic [7:0] mul_z = {lower_left_in, z_val[7:1]};

  // Divide: shift left, trial subtract, keep it when the quotient bit is 1
  wire logic [7:0] y_shift = {y_val[6:0], upper_right_in};
  wire logic [7:0] y_trial = div_shifting ? y_shift : y_val;
  wire logic [8:0] div_diff = {1'b0, y_trial} + {1'b0, ~x_val} +
                              {8'h00, carry_in};
  wire logic quot_bit = div_diff[8] | (y_val[7] & div_shifting);
  wire logic [7:0] div_y = shift_path_control ? div_diff[7:0] :
                           y_shift;
  wire logic [7:0] div_z = {z_val[6:0], lower_right_in};

  // Carry leaves lesser units unregistered so the chain ripples in a cycle
  wire logic carry_comb = in_mul ? ~mul_sum[8] : div_diff[8];

  // Sequence counters and per-register write hits
  for (genvar i = 0; i < NUM_OPERANDS; i++) begin : g_seq
    wire logic step_hit = access_edge && (sel_code == 2'(i));
    assign seq_match[i] = (seq_cnt_reg[i] == pos_code);
    assign wr_hit[i] = step_hit & ~rw_read & seq_match[i];
    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        seq_cnt_reg[i] <= SEQ_START;
      end else if (clk_en) begin
        if (seq_reset) begin
          seq_cnt_reg[i] <= SEQ_START;
        end else if (step_hit) begin
          seq_cnt_reg[i] <= seq_cnt_reg[i] - 2'h1;
        end
      end
    end
  end

  // Operand next values: bus load, control clears, arithmetic step
  wire logic clr_y = ctrl_wr & wr_data[CTRL_CLR_Y];
  wire logic clr_z = ctrl_wr & wr_data[CTRL_CLR_Z];
  wire logic [7:0] x_next = wr_hit[SEL_X] ? wr_data : x_val;
  wire logic [7:0] y_next =
    wr_hit[SEL_Y] ? wr_data : clr_y ? 8'h00 :
    (do_step & in_mul) ? mul_y : (do_step & in_div) ? div_y : y_val;
  wire logic [7:0] z_next =
    wr_hit[SEL_Z] ? wr_data : clr_z ? 8'h00 :
    (do_step & in_mul) ? mul_z : (do_step & in_div) ? div_z : z_val;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      operand_reg[SEL_X] <= 8'h00;
      operand_reg[SEL_Y] <= 8'h00;
      operand_reg[SEL_Z] <= 8'h00;
    end else if (clk_en) begin
      operand_reg[SEL_X] <= x_next;
      operand_reg[SEL_Y] <= y_next;
      operand_reg[SEL_Z] <= z_next;
    end
  end

  // Operation sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (op_start && (wr_op == OP_MUL)) begin
          state_next = ST_MUL;
        end else if (op_start) begin
          state_next = ST_DIV;
        end
      end
      ST_MUL, ST_DIV: begin
        if (busy_step && last_step) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      step_reg <= 6'h00;
      total_reg <= 6'h00;
    end else if (clk_en) begin
      if (clear_sync) begin
        state_reg <= ST_IDLE;
      end else begin
        state_reg <= state_next;
      end
      if (op_start) begin
        step_reg <= 6'h00;
        total_reg <= shift_total;
      end else if (busy_step) begin
        step_reg <= step_reg + 6'h01;
      end
    end
  end

  // Control word and overflow latch
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_reg <= CTRL_RESET;
      overflow_reg <= 1'b0;
    end else if (clk_en) begin
      if (ctrl_wr) begin
        ctrl_reg <= wr_data;
        overflow_reg <= div_diff[8];
      end else if (clear_sync) begin
        ctrl_reg[CTRL_OP_MSB:CTRL_OP_LSB] <= 2'h0;
      end
    end
  end

  // Read path: registered bus answer
  wire logic rd_en = unit_en & rw_read;
  wire logic [7:0] status_byte = {STATUS_PAD, overflow_reg};
  wire logic rd_drive = rd_en & ((sel_code == SEL_CTRL) ? is_most :
                                 seq_match[sel_code]);
  wire logic [7:0] rd_data = (sel_code == SEL_CTRL) ? status_byte :
                             operand_reg[sel_code];

  // Port direction follows the next state so it settles with it
  wire logic left_drive = (state_next != ST_MUL);

  logic [7:0] bus_data_reg;
  logic bus_oe_reg;
  logic left_oe_reg;
  logic right_oe_reg;
  logic ovf_n_reg;
  logic ovf_oe_reg;
  logic shift_oe_reg;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bus_data_reg <= 8'h00;
      bus_oe_reg <= 1'b0;
      left_oe_reg <= 1'b1;
      right_oe_reg <= 1'b0;
      ovf_n_reg <= 1'b1;
      ovf_oe_reg <= 1'b0;
      shift_oe_reg <= 1'b0;
    end else if (clk_en) begin
      bus_data_reg <= rd_data;
      bus_oe_reg <= rd_drive;
      left_oe_reg <= left_drive;
      right_oe_reg <= ~left_drive;
      ovf_n_reg <= ~overflow_reg;
      ovf_oe_reg <= ~is_most | sel_high;
      shift_oe_reg <= is_most;
    end
  end

  assign bus_data_out = bus_data_reg;
  assign bus_data_oe = bus_oe_reg;

  // Head unit shows overflow; the others pass their carry on
  assign carry_out_overflow_n_out = is_most ? ovf_n_reg :
                                    carry_comb;
  assign carry_out_overflow_n_oe = ovf_oe_reg;

  // Ring links; the head's upper left carries the quotient bit out
  assign upper_left_out = is_most ? quot_bit : y_val[7];
  assign lower_left_out = z_val[7];
  assign upper_right_out = mul_sum[0];
  assign lower_right_out = z_val[0];
  assign upper_left_oe = left_oe_reg;
  assign lower_left_oe = left_oe_reg;
  assign upper_right_oe = right_oe_reg;
  assign lower_right_oe = right_oe_reg;

  assign shift_out = gen_pulse;
  assign shift_oe = shift_oe_reg;

endmodule : cmd_unit

// ### verification/cmd_unit_assertions.sv
// Checker for the multiply/divide unit, bound to its ports
`timescale 1ns/1ps
module cmd_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Host bus
  input wire logic [7:0] bus_data_out,
  input wire logic bus_data_oe,
  input wire logic unit_select_high,
  input wire logic reg_select_2,
  input wire logic reg_select_1,
  input wire logic reg_select_0,
  input wire logic read_write_select,
  input wire logic bus_strobe,
  // Chain
  input wire logic position_code_hi,
  input wire logic position_code_lo,
  input wire logic carry_out_overflow_n_out,
  input wire logic carry_out_overflow_n_oe,
  input wire logic upper_left_oe,
  input wire logic upper_right_oe,
  input wire logic lower_left_oe,
  input wire logic lower_right_oe,
  input wire logic shift_out,
  input wire logic shift_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic ms, en, rd_stat;
  logic [3:0] idle_reg;
  logic [5:0] pulses_reg;
  assign ms = position_code_hi & position_code_lo;
  assign en = unit_select_high & reg_select_2;
  assign rd_stat = en & read_write_select & reg_select_1 & reg_select_0;
  // Run count restarts after a quiet spell longer than any prescale gap
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      idle_reg <= 4'h0;
      pulses_reg <= 6'h00;
    end else if (shift_out) begin
      idle_reg <= 4'h0;
      pulses_reg <= pulses_reg + 6'h01;
    end else if (idle_reg < 4'h9) begin
      idle_reg <= idle_reg + 4'h1;
    end else begin
      pulses_reg <= 6'h00;
    end
  end
  a_ports_oppose:
    assert property (upper_left_oe != upper_right_oe)
    else $error("Upper ports not in opposite directions");
  a_ports_in_step:
    assert property (upper_right_oe == lower_right_oe
      && upper_left_oe == lower_left_oe)
    else $error("Upper and lower ports disagree in direction");
  a_bus_floats:
    assert property ((!en || !read_write_select)[*4] |-> !bus_data_oe)
    else $error("Bus driven while disabled or writing");
  a_status_drive:
    assert property ((ms && rd_stat)[*4] |->
      bus_data_oe && bus_data_out[7:1] == 7'h00)
    else $error("Status read not driven or upper bits set");
  a_ovf_enable:
    assert property ((ms && $stable(unit_select_high))[*5] |->
      carry_out_overflow_n_oe == unit_select_high)
    else $error("Overflow driver not following unit select");
  a_shift_driver:
    assert property (ms[*5] |-> shift_oe)
    else $error("Most significant unit not driving shift line");
  a_pulse_budget:
    assert property (pulses_reg <= 6'h21)
    else $error("Too many shift pulses in one operation");
  a_ovf_on_write:
    assert property (ms && shift_oe && $past(shift_oe)
      && $changed(carry_out_overflow_n_out) |-> !$past(bus_strobe, 1)
      || !$past(bus_strobe, 2) || !$past(bus_strobe, 3)
      || !$past(bus_strobe, 4) || !$past(bus_strobe, 5))
    else $error("Overflow output moved without a register write");
  c_shift: cover property (shift_out);
  c_overflow: cover property (ms && !carry_out_overflow_n_out);
  c_status: cover property (rd_stat && bus_data_oe);
endmodule : cmd_chk

bind cmd_unit cmd_chk u_chk (.clock, .reset, .bus_data_out, .bus_data_oe,
  .unit_select_high, .reg_select_2, .reg_select_1, .reg_select_0,
  .read_write_select, .bus_strobe, .position_code_hi, .position_code_lo,
  .carry_out_overflow_n_out, .carry_out_overflow_n_oe, .upper_left_oe,
  .upper_right_oe, .lower_left_oe, .lower_right_oe, .shift_out, .shift_oe);

// ### verification/cmd_ring_model.sv
// Far side of a one-unit chain: ring links, shift line and carry
`timescale 1ns/1ps
module cmd_ring_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Unit drives
  input wire logic upper_left_out,
  input wire logic upper_left_oe,
  input wire logic upper_right_out,
  input wire logic upper_right_oe,
  input wire logic lower_left_out,
  input wire logic lower_left_oe,
  input wire logic lower_right_out,
  input wire logic lower_right_oe,
  input wire logic shift_out,
  input wire logic shift_oe,
  // Wire levels seen by the unit
  output logic upper_left_in,
  output logic upper_right_in,
  output logic lower_left_in,
  output logic lower_right_in,
  output logic shift_path_control,
  output logic shift_in,
  output logic carry_in
);
  logic ring_a, ring_b, shift_line;
  logic [2:0] last_reg;
  // Undriven wires flip so a stale level never passes for data
  assign ring_a = upper_left_oe ? upper_left_out :
    lower_right_oe ? lower_right_out : ~last_reg[2];
  assign ring_b = upper_right_oe ? upper_right_out :
    lower_left_oe ? lower_left_out : ~last_reg[1];
  assign shift_line = shift_oe ? shift_out : ~last_reg[0];
  assign upper_left_in = ring_a;
  assign lower_right_in = ring_a;
  assign shift_path_control = ring_a;
  assign upper_right_in = ring_b;
  assign lower_left_in = ring_b;
  assign shift_in = shift_line;
  // Alone in the chain, the unit is also the least significant
  assign carry_in = 1'b1;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      last_reg <= 3'h0;
    end else begin
      last_reg <= {ring_a, ring_b, shift_line};
    end
  end
endmodule : cmd_ring_model

// ### verification/tb.sv
// Bench for one unit standing as a whole chain
`timescale 1ns/1ps
module tb;
  import cmd_pkg::*;
  logic clock, reset, unit_select_high, reg_select_2, reg_select_1;
  logic reg_select_0, read_write_select, bus_strobe, clear_n, carry_in;
  logic [7:0] bus_data_in, bus_data_out;
  logic bus_data_oe, carry_out_overflow_n_out, carry_out_overflow_n_oe;
  logic shift_path_control, shift_in, shift_out, shift_oe;
  logic upper_left_in, upper_left_out, upper_left_oe;
  logic upper_right_in, upper_right_out, upper_right_oe;
  logic lower_left_in, lower_left_out, lower_left_oe;
  logic lower_right_in, lower_right_out, lower_right_oe;
  int miscompares = 0, n_compared = 0, pulses = 0;
  int first_t = 0, last_t = 0, cyc = 0;
  always #5 clock = ~clock;
  cmd_unit dut (.clock, .reset, .clk_en(1'b1), .bus_data_in, .bus_data_out,
    .bus_data_oe, .unit_select_high, .reg_select_2, .reg_select_1,
    .reg_select_0, .read_write_select, .bus_strobe, .clear_n,
    .position_code_hi(1'b1), .position_code_lo(1'b1), .carry_in,
    .carry_out_overflow_n_out, .carry_out_overflow_n_oe, .shift_path_control,
    .upper_left_in, .upper_left_out, .upper_left_oe, .upper_right_in,
    .upper_right_out, .upper_right_oe, .lower_left_in, .lower_left_out,
    .lower_left_oe, .lower_right_in, .lower_right_out, .lower_right_oe,
    .shift_in, .shift_out, .shift_oe);
  cmd_ring_model partner (.clock, .reset, .upper_left_out, .upper_left_oe,
    .upper_right_out, .upper_right_oe, .lower_left_out, .lower_left_oe,
    .lower_right_out, .lower_right_oe, .shift_out, .shift_oe, .upper_left_in,
    .upper_right_in, .lower_left_in, .lower_right_in, .shift_path_control,
    .shift_in, .carry_in);
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (shift_out === 1'b1) begin
      if (pulses == 0) first_t <= cyc;
      last_t <= cyc;
      pulses <= pulses + 1;
    end
  end
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // Strobe low four clocks: the synchroniser needs two to see the fall
  task automatic wr(logic [1:0] s, logic [7:0] d);
    read_write_select = 1'b0;
    {reg_select_1, reg_select_0} = s;
    bus_data_in = d;
    tick(3);
    bus_strobe = 1'b0;
    tick(4);
    bus_strobe = 1'b1;
    tick(4);
  endtask : wr
  task automatic rd(logic [1:0] s, string what, logic [7:0] exp);
    read_write_select = 1'b1;
    {reg_select_1, reg_select_0} = s;
    tick(4);
    chk(what, bus_data_out, exp);
    chk("bus drive", {7'h00, bus_data_oe}, 8'h01);
  endtask : rd
  // Host holds off for the full shift count before touching operands
  task automatic op(logic [7:0] c, int m);
    pulses = 0;
    wr(SEL_CTRL, c);
    tick(9 * (m + 1) + 3);
    chk("shift pulses", 8'(pulses), 8'h09);
    chk("shift span", 8'(last_t - first_t), 8'(8 * (m + 1)));
  endtask : op
  task automatic load(logic [7:0] x, logic [7:0] y, logic [7:0] z);
    wr(SEL_CTRL, 8'h70);
    wr(SEL_X, x);
    wr(SEL_Y, y);
    wr(SEL_Z, z);
  endtask : load
  task automatic t_multiply;
    load(8'hd7, 8'h5a, 8'h3b);
    op(8'h79, 0);
    rd(SEL_Y, "product high", 8'(16'hd7 * 16'h3b >> 8));
    rd(SEL_Z, "product low", 8'(16'hd7 * 16'h3b));
    rd(SEL_X, "multiplier", 8'hd7);
    $display("multiply test done");
  endtask : t_multiply
  task automatic t_divide;
    load(8'h57, 8'h12, 8'h34);
    op(8'h72, 0);
    rd(SEL_Z, "quotient", 8'(16'h1234 / 16'h0057));
    rd(SEL_Y, "remainder", 8'(16'h1234 % 16'h0057));
    rd(SEL_X, "divisor", 8'h57);
    rd(SEL_CTRL, "status", 8'h00);
    chk("overflow pin", {7'h00, carry_out_overflow_n_out}, 8'h01);
    $display("divide test done");
  endtask : t_divide
  task automatic t_overflow;
    load(8'h57, 8'h60, 8'h00);
    op(8'h72, 0);
    rd(SEL_CTRL, "status", 8'h01);
    chk("overflow pin", {7'h00, carry_out_overflow_n_out}, 8'h00);
    reg_select_2 = 1'b0;
    tick(4);
    chk("overflow drive", {7'h00, carry_out_overflow_n_oe}, 8'h01);
    chk("bus float", {7'h00, bus_data_oe}, 8'h00);
    reg_select_2 = 1'b1;
    unit_select_high = 1'b0;
    tick(4);
    chk("overflow drive", {7'h00, carry_out_overflow_n_oe}, 8'h00);
    chk("bus float", {7'h00, bus_data_oe}, 8'h00);
    unit_select_high = 1'b1;
    $display("overflow test done");
  endtask : t_overflow
  task automatic t_prescale;
    load(8'h0f, 8'h33, 8'h0f);
    op(8'hf9, 1);
    rd(SEL_Z, "product low", 8'he1);
    rd(SEL_Y, "product high", 8'h00);
    $display("prescale test done");
  endtask : t_prescale
  task automatic t_sequence;
    wr(SEL_CTRL, 8'h70);
    wr(SEL_X, 8'h11);
    wr(SEL_X, 8'h22);
    wr(SEL_CTRL, 8'h70);
    rd(SEL_X, "second write refused", 8'h11);
    wr(SEL_X, 8'h33);
    clear_n = 1'b0;
    tick(4);
    clear_n = 1'b1;
    tick(4);
    wr(SEL_X, 8'h44);
    wr(SEL_CTRL, 8'h70);
    rd(SEL_X, "write after clear", 8'h44);
    $display("sequence test done");
  endtask : t_sequence
  task automatic t_disabled;
    unit_select_high = 1'b0;
    wr(SEL_X, 8'hee);
    unit_select_high = 1'b1;
    reg_select_2 = 1'b0;
    wr(SEL_X, 8'hdd);
    reg_select_2 = 1'b1;
    wr(SEL_CTRL, 8'h70);
    rd(SEL_X, "disabled writes", 8'h44);
    $display("disabled test done");
  endtask : t_disabled
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  initial begin
    repeat (100000) @(posedge clock);
    miscompares++;
    results();
  end
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    bus_data_in = 8'h00;
    unit_select_high = 1'b1;
    reg_select_2 = 1'b1;
    {reg_select_1, reg_select_0} = SEL_X;
    read_write_select = 1'b0;
    bus_strobe = 1'b1;
    clear_n = 1'b1;
    tick(3);
    reset = 1'b0;
    tick(5);
    t_multiply();
    t_divide();
    t_overflow();
    t_prescale();
    t_sequence();
    t_disabled();
    results();
  end
endmodule : tb
